/* File: design/ccdc_pkg.sv */
// ****************************************************************
// register map, field layout and source codes
// ****************************************************************
package ccdc_pkg;

  // register offsets
  localparam logic [7:0] OFS_BITCLK_HIGH = 8'h3B;
  localparam logic [7:0] OFS_PBCLK_LOW = 8'h3C;
  localparam logic [7:0] OFS_SBCLK_LOW = 8'h3D;
  localparam logic [7:0] OFS_ANALOG_NM = 8'h3E;
  localparam logic [7:0] OFS_CORE_EN = 8'h44;
  localparam logic [7:0] OFS_PATH_EN = 8'h45;
  localparam logic [7:0] OFS_CLKOUT_SRC = 8'h46;
  localparam logic [7:0] OFS_CLOCK_OUTPUT_RATIO = 8'h47;
  localparam logic [7:0] OFS_BOOST_CFG = 8'h48;
  localparam logic [7:0] OFS_AUX_CFG = 8'h49;

  // writable bits per register, reserved bits stay zero
  localparam logic [7:0] MSK_BITCLK_HIGH = 8'h06;
  localparam logic [7:0] MSK_FULL = 8'hFF;
  localparam logic [7:0] MSK_ANALOG_NM = 8'h3F;
  localparam logic [7:0] MSK_CORE_EN = 8'h07;
  localparam logic [7:0] MSK_CLKOUT_SRC = 8'h07;
  localparam logic [7:0] MSK_BOOST_CFG = 8'h7F;

  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ONE = 8'h01;

  // bit positions
  localparam int BIT_PBCLK_HIGH = 2;
  localparam int BIT_SBCLK_HIGH = 1;
  localparam int BIT_N_ON = 2;
  localparam int BIT_M_ON = 1;
  localparam int BIT_PDM_ON = 0;
  localparam int BIT_REC_DEM_ON = 7;
  localparam int BIT_REC_MOD_ON = 6;
  localparam int BIT_PLAY_DEM_ON = 5;
  localparam int BIT_PLAY_MOD_ON = 4;
  localparam int BIT_PBCLK_ON = 3;
  localparam int BIT_SBCLK_ON = 2;
  localparam int BIT_PFS_ON = 1;
  localparam int BIT_SFS_ON = 0;
  localparam int BIT_CLKOUT_ON = 7;
  localparam int BIT_BST_FREQ = 6;
  localparam int BIT_SRC_MANUAL = 5;
  localparam int BIT_SRC_OSC = 4;
  localparam int BIT_EN_MANUAL = 3;
  localparam int BIT_MANUAL_ON = 2;
  localparam int AUX_FREQ_MSB = 7;
  localparam int AUX_FREQ_LSB = 6;
  localparam int RATIO_MSB = 1;

  // field widths
  localparam int BITCLK_CODE_W = 9;
  localparam int NM_CODE_W = 6;
  localparam int CLKOUT_CODE_W = 7;
  localparam int POW2_W = 6;

  // clock source indices, equal to the clock-output source codes
  localparam int NUM_SRC = 6;
  localparam logic [2:0] SRC_PLL = 3'h0;
  localparam logic [2:0] SRC_PBCLK = 3'h1;
  localparam logic [2:0] SRC_SBCLK = 3'h2;
  localparam logic [2:0] SRC_CONTROLLER_MASTER_CLOCK = 3'h3;
  localparam logic [2:0] SRC_OSC = 3'h4;
  localparam logic [2:0] SRC_DSP = 3'h5;

  // auxiliary converter frequency codes
  localparam logic [1:0] AUX_FREQ_12M = 2'h3;

endpackage : ccdc_pkg

/* File: design/ccdc_divider.sv */
`timescale 1ns/1ps
// ****************************************************************
// edge-counting divider of a sampled source clock
// ****************************************************************
module ccdc_divider #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // control
  input wire logic en,
  input wire logic [W:0] ratio,
  // source as sampled level and rising-edge pulse
  input wire logic src_lvl,
  input wire logic src_rise,
  // divided clock
  output logic div_out
);

  // refuse widths the counter cannot serve
  if (W < 1) begin : g_bad_w
    $error("ccdc_divider: W must be at least 1");
  end

  localparam logic [W:0] ONE = {{W{1'b0}}, 1'b1};

  typedef struct packed {
    logic [W:0] cnt_r; // source edges counted in this period
    logic out_r; // divided clock level
  } ccdc_div_t;

  ccdc_div_t state_r;
  ccdc_div_t state_nxt;
  logic [W:0] cnt_step; // counter after this edge
  logic [W:0] half; // edges spent high per period

  // next-state logic
  always_comb begin
    state_nxt = state_r;
    half = ratio >> 1;
    cnt_step = state_r.cnt_r + ONE;
    if (cnt_step >= ratio) begin
      cnt_step = '0;
    end
    if (!en) begin
      // disabled: static low, counter held at zero
      state_nxt.cnt_r = '0;
      state_nxt.out_r = 1'b0;
    end else if (ratio == ONE) begin
      // divide by one follows the source
      state_nxt.cnt_r = '0;
      state_nxt.out_r = src_lvl;
    end else if (src_rise) begin
      // high for the first half of each period
      state_nxt.cnt_r = cnt_step;
      state_nxt.out_r = (cnt_step < half);
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign div_out = state_r.out_r;

endmodule : ccdc_divider

/* File: design/ccdc_clock_divider_control.sv */
`timescale 1ns/1ps
// What this block does
// - primary bit-clock high bit at bit 2
// - secondary bit-clock high bit at bit 1
// - nine-bit bit-clock code, zero divides by 512
// - auto detection overrides programmed bit-clock and analog codes
// - six-bit analog ratio, zero divides by 64
// - n, m, pdm enables at bits 2..0
// - dem and modulator enables at bits 7..4
// - bit-clock and frame-sync enables at bits 3..0
// - clock-output source code, six sources, two reserved
// - clock-output divider runs only with bit 7
// - seven-bit clock-output ratio, zero divides by 128
// - boost bit 6 picks six or three MHz
// - boost source automatic unless bit 5 set
// - manual boost source: audio or oscillator
// - boost enable automatic unless bit 3 set
// - manual boost enable bit 2
// - manual boost ratio 1, 2, 4, 8
// - aux frequency code, twelve MHz needs oscillator
// - aux divider copies the boost source and enable scheme, with its own bits 5..2
module ccdc_clock_divider_control
  import ccdc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // source clocks, asynchronous to mclk
  input wire logic pll_clk,
  input wire logic primary_serial_port_bitclk,
  input wire logic secondary_serial_port_bitclk,
  input wire logic controller_master_clock,
  input wire logic osc_clk,
  input wire logic dsp_clk,
  // clock detection results, mclk domain
  input wire logic auto_detect_en,
  input wire logic [BITCLK_CODE_W-1:0] auto_primary_code,
  input wire logic [BITCLK_CODE_W-1:0] auto_secondary_code,
  input wire logic [NM_CODE_W-1:0] auto_nm_code,
  input wire logic auto_aux_from_osc,
  input wire logic auto_aux_on,
  // divided clocks
  output logic primary_bitclk_div_out,
  output logic secondary_bitclk_div_out,
  output logic analog_nm_clk,
  output logic clock_output_clk,
  output logic boost_clk,
  output logic aux_converter_clk,
  // divider enables for the rest of the clock tree
  output logic n_divider_on,
  output logic m_divider_on,
  output logic pdm_divider_on,
  output logic record_dem_divider_on,
  output logic record_modulator_divider_on,
  output logic playback_dem_divider_on,
  output logic playback_modulator_divider_on,
  output logic primary_framesync_divider_on,
  output logic secondary_framesync_divider_on
);

  // ****************************************************************
  // state
  // ****************************************************************

  typedef struct packed {
    logic [7:0] high_r; // bit-clock high bits
    logic [7:0] plow_r; // primary bit-clock low byte
    logic [7:0] slow_r; // secondary bit-clock low byte
    logic [7:0] nm_r; // analog n-m ratio
    logic [7:0] core_r; // core divider enables
    logic [7:0] path_r; // path divider enables
    logic [7:0] osrc_r; // clock-output source
    logic [7:0] odiv_r; // clock-output enable and ratio
    logic [7:0] bst_r; // boost clock configuration
    logic [7:0] aux_r; // aux converter clock configuration
    logic [7:0] rdata_r; // read data
    logic [NUM_SRC-1:0] s1_r; // first synchroniser stage
    logic [NUM_SRC-1:0] s2_r; // second synchroniser stage
    logic [NUM_SRC-1:0] prev_r; // delayed copy for edge detect
  } ccdc_state_t;

  ccdc_state_t state_r;
  ccdc_state_t state_nxt;

  // ****************************************************************
  // source sampling
  // ****************************************************************

  logic [NUM_SRC-1:0] src_raw; // raw source pins
  logic [NUM_SRC-1:0] src_lvl; // synchronised levels
  logic [NUM_SRC-1:0] src_rise; // one-cycle rising-edge pulses

  assign src_raw[SRC_PLL] = pll_clk;
  assign src_raw[SRC_PBCLK] = primary_serial_port_bitclk;
  assign src_raw[SRC_SBCLK] = secondary_serial_port_bitclk;
  assign src_raw[SRC_CONTROLLER_MASTER_CLOCK] = controller_master_clock;
  assign src_raw[SRC_OSC] = osc_clk;
  assign src_raw[SRC_DSP] = dsp_clk;
  assign src_lvl = state_r.s2_r;
  assign src_rise = state_r.s2_r & ~state_r.prev_r;

  // ****************************************************************
  // register file
  // ****************************************************************

  // writes store only the writable bits, reads return the register
  always_comb begin
    state_nxt = state_r;
    state_nxt.s1_r = src_raw;
    state_nxt.s2_r = state_r.s1_r;
    state_nxt.prev_r = state_r.s2_r;
    if (reg_wr) begin
      // reserved bits are masked so they read back as zero
      case (reg_addr)
        OFS_BITCLK_HIGH: begin
          state_nxt.high_r = reg_wdata & MSK_BITCLK_HIGH;
        end
        OFS_PBCLK_LOW: begin
          state_nxt.plow_r = reg_wdata & MSK_FULL;
        end
        OFS_SBCLK_LOW: begin
          state_nxt.slow_r = reg_wdata & MSK_FULL;
        end
        OFS_ANALOG_NM: begin
          state_nxt.nm_r = reg_wdata & MSK_ANALOG_NM;
        end
        OFS_CORE_EN: begin
          state_nxt.core_r = reg_wdata & MSK_CORE_EN;
        end
        OFS_PATH_EN: begin
          state_nxt.path_r = reg_wdata & MSK_FULL;
        end
        OFS_CLKOUT_SRC: begin
          state_nxt.osrc_r = reg_wdata & MSK_CLKOUT_SRC;
        end
        OFS_CLOCK_OUTPUT_RATIO: begin
          state_nxt.odiv_r = reg_wdata & MSK_FULL;
        end
        OFS_BOOST_CFG: begin
          state_nxt.bst_r = reg_wdata & MSK_BOOST_CFG;
        end
        OFS_AUX_CFG: begin
          state_nxt.aux_r = reg_wdata & MSK_FULL;
        end
        default: begin
          // unmapped writes are dropped
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        OFS_BITCLK_HIGH: state_nxt.rdata_r = state_r.high_r;
        OFS_PBCLK_LOW: state_nxt.rdata_r = state_r.plow_r;
        OFS_SBCLK_LOW: state_nxt.rdata_r = state_r.slow_r;
        OFS_ANALOG_NM: state_nxt.rdata_r = state_r.nm_r;
        OFS_CORE_EN: state_nxt.rdata_r = state_r.core_r;
        OFS_PATH_EN: state_nxt.rdata_r = state_r.path_r;
        OFS_CLKOUT_SRC: state_nxt.rdata_r = state_r.osrc_r;
        OFS_CLOCK_OUTPUT_RATIO: state_nxt.rdata_r = state_r.odiv_r;
        OFS_BOOST_CFG: state_nxt.rdata_r = state_r.bst_r;
        OFS_AUX_CFG: state_nxt.rdata_r = state_r.aux_r;
        default: state_nxt.rdata_r = RST_ZERO;
      endcase
    end
  end

  // state register with documented reset values
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_r <= '0;
      state_r.high_r <= RST_ZERO;
      state_r.plow_r <= RST_ONE;
      state_r.slow_r <= RST_ONE;
      state_r.nm_r <= RST_ONE;
      state_r.core_r <= RST_ZERO;
      state_r.path_r <= RST_ZERO;
      state_r.osrc_r <= RST_ZERO;
      state_r.odiv_r <= RST_ONE;
      state_r.bst_r <= RST_ZERO;
      state_r.aux_r <= RST_ZERO;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // ratio and source decode
  // ****************************************************************

  logic [BITCLK_CODE_W-1:0] pcode; // effective primary code
  logic [BITCLK_CODE_W-1:0] scode; // effective secondary code
  logic [NM_CODE_W-1:0] nmcode; // effective analog code
  logic [CLKOUT_CODE_W-1:0] ocode; // clock-output code
  logic [BITCLK_CODE_W:0] pratio;
  logic [BITCLK_CODE_W:0] sratio;
  logic [NM_CODE_W:0] nmratio;
  logic [CLKOUT_CODE_W:0] oratio;
  logic [2:0] osel; // clock-output source code
  logic osel_ok; // source code is not reserved
  logic o_lvl;
  logic o_rise;
  logic bst_osc; // boost runs from the oscillator
  logic bst_on;
  logic [2:0] bst_shift;
  logic [POW2_W:0] bst_ratio;
  logic aux_osc; // aux runs from the oscillator
  logic aux_on;
  logic [1:0] aux_freq;
  logic [2:0] aux_shift;
  logic [POW2_W:0] aux_ratio;

  // bit-clock and analog codes, overridden by detection
  assign pcode = auto_detect_en ? auto_primary_code
               : {state_r.high_r[BIT_PBCLK_HIGH], state_r.plow_r};
  assign scode = auto_detect_en ? auto_secondary_code
               : {state_r.high_r[BIT_SBCLK_HIGH], state_r.slow_r};
  assign nmcode = auto_detect_en ? auto_nm_code : state_r.nm_r[NM_CODE_W-1:0];
  assign ocode = state_r.odiv_r[CLKOUT_CODE_W-1:0];

  // a zero code sets only the top ratio bit: 512, 64 or 128
  assign pratio = {pcode == '0, pcode};
  assign sratio = {scode == '0, scode};
  assign nmratio = {nmcode == '0, nmcode};
  assign oratio = {ocode == '0, ocode};

  // clock-output source mux, reserved codes feed no edges
  assign osel = state_r.osrc_r[2:0];
  assign osel_ok = (osel <= SRC_DSP);
  assign o_lvl = osel_ok ? src_lvl[osel] : 1'b0;
  assign o_rise = osel_ok ? src_rise[osel] : 1'b0;

  // boost source, enable and power-of-two ratio
  always_comb begin
    bst_osc = state_r.bst_r[BIT_SRC_MANUAL] ? state_r.bst_r[BIT_SRC_OSC]
            : auto_aux_from_osc;
    bst_on = state_r.bst_r[BIT_EN_MANUAL] ? state_r.bst_r[BIT_MANUAL_ON]
           : auto_aux_on;
    bst_shift = '0;
    if (state_r.bst_r[BIT_SRC_MANUAL]) begin
      bst_shift = {1'b0, state_r.bst_r[RATIO_MSB:0]};
    end
    // three MHz mode halves the clock once more
    bst_shift = bst_shift + {2'b00, state_r.bst_r[BIT_BST_FREQ]};
    bst_ratio = {{POW2_W{1'b0}}, 1'b1} << bst_shift;
  end

  // aux converter clock: same scheme plus a two-bit frequency code
  always_comb begin
    aux_osc = state_r.aux_r[BIT_SRC_MANUAL] ? state_r.aux_r[BIT_SRC_OSC]
            : auto_aux_from_osc;
    aux_on = state_r.aux_r[BIT_EN_MANUAL] ? state_r.aux_r[BIT_MANUAL_ON]
           : auto_aux_on;
    aux_freq = state_r.aux_r[AUX_FREQ_MSB:AUX_FREQ_LSB];
    aux_shift = '0;
    if (state_r.aux_r[BIT_SRC_MANUAL]) begin
      aux_shift = {1'b0, state_r.aux_r[RATIO_MSB:0]};
    end
    // twelve MHz is undivided and only from the oscillator
    if (aux_freq == AUX_FREQ_12M) begin
      if (!aux_osc) begin
        aux_shift = aux_shift + 3'h1;
      end
    end else begin
      aux_shift = aux_shift + {1'b0, aux_freq} + 3'h1;
    end
    aux_ratio = {{POW2_W{1'b0}}, 1'b1} << aux_shift;
  end

  // ****************************************************************
  // dividers
  // ****************************************************************

  // primary bit-clock divider
  ccdc_divider #(.W(BITCLK_CODE_W)) u_pbclk (
    .mclk(mclk),
    .resetn(resetn),
    .en(state_r.path_r[BIT_PBCLK_ON]),
    .ratio(pratio),
    .src_lvl(src_lvl[SRC_PLL]),
    .src_rise(src_rise[SRC_PLL]),
    .div_out(primary_bitclk_div_out)
  );

  // secondary bit-clock divider
  ccdc_divider #(.W(BITCLK_CODE_W)) u_sbclk (
    .mclk(mclk),
    .resetn(resetn),
    .en(state_r.path_r[BIT_SBCLK_ON]),
    .ratio(sratio),
    .src_lvl(src_lvl[SRC_PLL]),
    .src_rise(src_rise[SRC_PLL]),
    .div_out(secondary_bitclk_div_out)
  );

  // analog n-m divider, gated by the n divider enable
  ccdc_divider #(.W(NM_CODE_W)) u_nm (
    .mclk(mclk),
    .resetn(resetn),
    .en(state_r.core_r[BIT_N_ON]),
    .ratio(nmratio),
    .src_lvl(src_lvl[SRC_PLL]),
    .src_rise(src_rise[SRC_PLL]),
    .div_out(analog_nm_clk)
  );

  // general purpose clock-output divider
  ccdc_divider #(.W(CLKOUT_CODE_W)) u_clkout (
    .mclk(mclk),
    .resetn(resetn),
    .en(state_r.odiv_r[BIT_CLKOUT_ON] && osel_ok),
    .ratio(oratio),
    .src_lvl(o_lvl),
    .src_rise(o_rise),
    .div_out(clock_output_clk)
  );

  // boost converter clock divider
  ccdc_divider #(.W(POW2_W)) u_boost (
    .mclk(mclk),
    .resetn(resetn),
    .en(bst_on),
    .ratio(bst_ratio),
    .src_lvl(bst_osc ? src_lvl[SRC_OSC] : src_lvl[SRC_PLL]),
    .src_rise(bst_osc ? src_rise[SRC_OSC] : src_rise[SRC_PLL]),
    .div_out(boost_clk)
  );

  // aux converter clock divider
  ccdc_divider #(.W(POW2_W)) u_aux (
    .mclk(mclk),
    .resetn(resetn),
    .en(aux_on),
    .ratio(aux_ratio),
    .src_lvl(aux_osc ? src_lvl[SRC_OSC] : src_lvl[SRC_PLL]),
    .src_rise(aux_osc ? src_rise[SRC_OSC] : src_rise[SRC_PLL]),
    .div_out(aux_converter_clk)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************

  assign reg_rdata = state_r.rdata_r;
  assign n_divider_on = state_r.core_r[BIT_N_ON];
  assign m_divider_on = state_r.core_r[BIT_M_ON];
  assign pdm_divider_on = state_r.core_r[BIT_PDM_ON];
  assign record_dem_divider_on = state_r.path_r[BIT_REC_DEM_ON];
  assign record_modulator_divider_on = state_r.path_r[BIT_REC_MOD_ON];
  assign playback_dem_divider_on = state_r.path_r[BIT_PLAY_DEM_ON];
  assign playback_modulator_divider_on = state_r.path_r[BIT_PLAY_MOD_ON];
  assign primary_framesync_divider_on = state_r.path_r[BIT_PFS_ON];
  assign secondary_framesync_divider_on = state_r.path_r[BIT_SFS_ON];

endmodule : ccdc_clock_divider_control

/* File: sim/ccdc_asserts.sv */
`timescale 1ns/1ps
// ****************************************************************
// register-port and divider-gating checks
// ****************************************************************
module ccdc_asserts
  import ccdc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // divided clocks
  input wire logic primary_bitclk_div_out,
  input wire logic analog_nm_clk,
  input wire logic clock_output_clk,
  input wire logic boost_clk,
  // enables
  input wire logic n_divider_on,
  input wire logic m_divider_on,
  input wire logic pdm_divider_on,
  input wire logic record_dem_divider_on,
  input wire logic playback_modulator_divider_on,
  input wire logic primary_framesync_divider_on
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  logic co_on_r; // shadow of clock-output enable
  logic [2:0] co_src_r; // shadow of clock-output source code
  logic pb_on_r; // shadow of primary bit-clock enable
  logic bst_off_r; // boost forced off by manual enable mode

  // shadow copies of the gating bits, updated with the register writes
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      co_on_r <= 1'b0;
      co_src_r <= 3'h0;
      pb_on_r <= 1'b0;
      bst_off_r <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == OFS_CLOCK_OUTPUT_RATIO) co_on_r <= reg_wdata[BIT_CLKOUT_ON];
      if (reg_addr == OFS_CLKOUT_SRC) co_src_r <= reg_wdata[2:0];
      if (reg_addr == OFS_PATH_EN) pb_on_r <= reg_wdata[BIT_PBCLK_ON];
      if (reg_addr == OFS_BOOST_CFG) bst_off_r <= reg_wdata[3] & ~reg_wdata[2];
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  core_en_read_a: assert property (reg_rd && reg_addr == OFS_CORE_EN |=>
    reg_rdata == {5'h00, $past(n_divider_on), $past(m_divider_on), $past(pdm_divider_on)})
    else $error("core enable readback wrong");
  path_en_write_a: assert property (reg_wr && reg_addr == OFS_PATH_EN |=>
    {record_dem_divider_on, playback_modulator_divider_on, primary_framesync_divider_on}
    == {$past(reg_wdata[7]), $past(reg_wdata[4]), $past(reg_wdata[1])})
    else $error("path enable outputs wrong");
  unmapped_read_a: assert property (reg_rd && reg_addr == 8'h50 |=>
    reg_rdata == RST_ZERO) else $error("unmapped read not zero");
  clkout_off_a: assert property (!co_on_r && !$past(co_on_r)
    && !$past(co_on_r, 2) |-> !clock_output_clk)
    else $error("clock output runs while disabled");
  reserved_src_a: assert property (co_src_r > 3'h5 && $past(co_src_r) > 3'h5
    && $past(co_src_r, 2) > 3'h5 |-> !clock_output_clk) else $error("reserved source runs");
  pbclk_off_a: assert property (!pb_on_r && !$past(pb_on_r)
    && !$past(pb_on_r, 2) |-> !primary_bitclk_div_out)
    else $error("bit clock runs while disabled");
  nm_gate_a: assert property (!n_divider_on && !$past(n_divider_on)
    && !$past(n_divider_on, 2) |-> !analog_nm_clk) else $error("analog ratio clock ungated");
  boost_off_a: assert property (bst_off_r && $past(bst_off_r) && $past(bst_off_r, 2)
    |-> !boost_clk) else $error("boost runs while manually off");
  reset_clear_a: assert property (disable iff (1'b0) !resetn |=>
    reg_rdata == RST_ZERO && !clock_output_clk && !n_divider_on)
    else $error("reset state wrong");
endmodule : ccdc_asserts

bind ccdc_clock_divider_control ccdc_asserts ccdc_asserts_i (
  .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .primary_bitclk_div_out(primary_bitclk_div_out), .analog_nm_clk(analog_nm_clk),
  .clock_output_clk(clock_output_clk), .boost_clk(boost_clk),
  .n_divider_on(n_divider_on), .m_divider_on(m_divider_on), .pdm_divider_on(pdm_divider_on),
  .record_dem_divider_on(record_dem_divider_on),
  .playback_modulator_divider_on(playback_modulator_divider_on),
  .primary_framesync_divider_on(primary_framesync_divider_on));

/* File: sim/tb.sv */
`timescale 1ns/1ps
// ****************************************************************
// self-checking bench: register table, then divider periods
// ****************************************************************
module tb;
  import ccdc_pkg::*;
  logic mclk, resetn, reg_wr, reg_rd; // clock, reset, strobes
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d; // register port
  logic [9:0] src_cnt = 10'h000; // source clocks come from its bits
  logic auto_detect_en, auto_aux_from_osc, auto_aux_on; // detection inputs
  logic [8:0] auto_primary_code, auto_secondary_code;
  logic [5:0] auto_nm_code;
  logic [5:0] div_clk; // divided clocks
  logic [8:0] en_out; // enable outputs
  int miscompares, n_checks;
  // register rows: address, reset value, writable mask that is written and read back
  logic [7:0] row_addr [11] = '{8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h44, 8'h45, 8'h46, 8'h47,
    8'h48, 8'h49, 8'h50};
  logic [7:0] row_rst [11] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01,
    8'h00, 8'h00, 8'h00};
  logic [7:0] row_msk [11] = '{8'h06, 8'hFF, 8'hFF, 8'h3F, 8'h07, 8'hFF, 8'h07, 8'hFF,
    8'h7F, 8'hFF, 8'h00};

  ccdc_clock_divider_control ccdc_clock_divider_control_i (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pll_clk(src_cnt[2]), .primary_serial_port_bitclk(src_cnt[3]),
    .secondary_serial_port_bitclk(src_cnt[4]), .controller_master_clock(src_cnt[5]),
    .osc_clk(src_cnt[6]), .dsp_clk(src_cnt[7]), .auto_detect_en(auto_detect_en),
    .auto_primary_code(auto_primary_code), .auto_secondary_code(auto_secondary_code),
    .auto_nm_code(auto_nm_code), .auto_aux_from_osc(auto_aux_from_osc),
    .auto_aux_on(auto_aux_on), .primary_bitclk_div_out(div_clk[0]),
    .secondary_bitclk_div_out(div_clk[1]), .analog_nm_clk(div_clk[2]),
    .clock_output_clk(div_clk[3]), .boost_clk(div_clk[4]), .aux_converter_clk(div_clk[5]),
    .n_divider_on(en_out[8]), .m_divider_on(en_out[7]), .pdm_divider_on(en_out[6]),
    .record_dem_divider_on(en_out[5]), .record_modulator_divider_on(en_out[4]),
    .playback_dem_divider_on(en_out[3]), .playback_modulator_divider_on(en_out[2]),
    .primary_framesync_divider_on(en_out[1]), .secondary_framesync_divider_on(en_out[0]));

  // clock and free-running source counter
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) src_cnt <= src_cnt + 10'h001;

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  // one register write, strobe for one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // one register read, data taken 1 ns after the edge that samples the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  // period of one divided clock in mclk cycles, zero if it rises fewer than three times
  task automatic per_chk(input int k, input int e);
    int c, r, n;
    logic pv;
    logic [31:0] p;
    p = 0;
    c = 0;
    r = 0;
    n = 0;
    pv = div_clk[k];
    while (r < 3 && n < 3 * e + 600) begin
      @(posedge mclk);
      #1;
      c++;
      n++;
      if (div_clk[k] === 1'b1 && pv === 1'b0) begin
        r++;
        if (r == 3) p = c;
        c = 0;
      end
      pv = div_clk[k];
    end
    chk(p, e);
  endtask : per_chk

  // verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // watchdog against a hang
  initial begin
    repeat (90000) @(posedge mclk);
    miscompares++;
    results();
  end

  // main sequence
  initial begin
    {resetn, reg_wr, reg_rd, auto_detect_en, auto_aux_from_osc, auto_aux_on} = 6'h00;
    {reg_addr, reg_wdata} = 16'h0;
    {auto_primary_code, auto_secondary_code, auto_nm_code} = 24'h0;
    miscompares = 0;
    n_checks = 0;
    repeat (9) @(posedge mclk);
    #1;
    chk({div_clk, en_out, reg_rdata}, 0);
    @(posedge mclk) resetn <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      rd(row_addr[i], d);
      chk(d, row_rst[i]);
      wr(row_addr[i], row_msk[i]);
      rd(row_addr[i], d);
      chk(d, row_msk[i]);
    end
    wr(8'h47, 8'h81);
    for (int s = 0; s < 8; s++) begin
      wr(8'h46, 8'(s));
      per_chk(3, s < 6 ? 8 << s : 0);
    end
    wr(8'h46, 8'h00);
    wr(8'h47, 8'h83);
    per_chk(3, 24);
    wr(8'h47, 8'h80);
    per_chk(3, 1024);
    wr(8'h47, 8'h03);
    per_chk(3, 0);
    wr(8'h3C, 8'h00);
    per_chk(0, 2048);
    wr(8'h3B, 8'h00);
    per_chk(0, 4096);
    wr(8'h3C, 8'h05);
    per_chk(0, 40);
    wr(8'h3B, 8'h02);
    wr(8'h3D, 8'h02);
    per_chk(1, 2064);
    wr(8'h3E, 8'h00);
    per_chk(2, 512);
    wr(8'h3E, 8'h03);
    per_chk(2, 24);
    @(posedge mclk);
    auto_primary_code <= 9'h004;
    auto_secondary_code <= 9'h003;
    auto_nm_code <= 6'h02;
    auto_detect_en <= 1'b1;
    per_chk(0, 32);
    per_chk(1, 24);
    per_chk(2, 16);
    @(posedge mclk) auto_detect_en <= 1'b0;
    wr(8'h48, 8'h2E);
    per_chk(4, 32);
    wr(8'h48, 8'h6E);
    per_chk(4, 64);
    wr(8'h48, 8'h3E);
    per_chk(4, 512);
    wr(8'h48, 8'h2A);
    per_chk(4, 0);
    wr(8'h48, 8'h10);
    @(posedge mclk) auto_aux_on <= 1'b1;
    per_chk(4, 8);
    @(posedge mclk) auto_aux_from_osc <= 1'b1;
    per_chk(4, 128);
    @(posedge mclk) auto_aux_on <= 1'b0;
    per_chk(4, 0);
    wr(8'h49, 8'h2D);
    per_chk(5, 32);
    wr(8'h49, 8'hAD);
    per_chk(5, 128);
    wr(8'h49, 8'hEC);
    per_chk(5, 16);
    wr(8'h49, 8'hFC);
    per_chk(5, 128);
    wr(8'h45, 8'h96);
    wr(8'h44, 8'h05);
    #1;
    chk(en_out, 9'h166);
    per_chk(0, 0);
    per_chk(2, 24);
    wr(8'h44, 8'h00);
    per_chk(2, 0);
    @(posedge mclk) resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk({div_clk, en_out}, 0);
    @(posedge mclk) resetn <= 1'b1;
    rd(8'h47, d);
    chk(d, 8'h01);
    results();
  end
endmodule : tb
